// ---- shared/nest_seq_pkg.sv ----
// Shared constants and types for the nested interrupt sequencer control block
package nest_seq_pkg;
  // ****************************************
  // Register map (byte addresses)
  // ****************************************
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_MASK = 8'h04;
  localparam logic [7:0] OFF_LATCH = 8'h08;
  localparam logic [7:0] OFF_LATCH2 = 8'h0c;
  localparam logic [7:0] OFF_MASKPTR = 8'h10;
  localparam logic [7:0] OFF_PCSP = 8'h14;
  localparam logic [7:0] OFF_FETCH = 8'h18;
  // ****************************************
  // Field positions and reset values
  // ****************************************
  localparam int NEST_BIT = 11;
  localparam int GIE_BIT = 12;
  localparam int SAT_BIT = 13;
  localparam logic [31:0] MODE_RST = 32'h0000_0000;
  localparam logic [31:0] MASK_RST = 32'h0000_0000;
  localparam logic [31:0] WAKE_MASK_DFLT = 32'hffff_ffff;
  // ****************************************
  // Sizes and timing counts
  // ****************************************
  localparam int N_IRQ = 32;
  localparam int VEC_W = 5;
  localparam int PCSP_W = 5;
  localparam int SAT_DELAY = 2;
  localparam int WAKE_LAT = 5;
  localparam int WAKE_W = 3;
  localparam logic [WAKE_W-1:0] WAKE_LAST = WAKE_W'(WAKE_LAT - 1);
  localparam logic [1:0] RD_WAIT = 2'h2;
  // ****************************************
  // Sequencer power states
  // ****************************************
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_HALT = 2'b01,
    ST_WAKE = 2'b10
  } seq_state_t;
endpackage

// ---- hw/prio_pick.sv ----
// Fixed priority picker: lowest set index wins
`timescale 1ns/1ps
module prio_pick #(
  parameter int N = 32,
  parameter int W = 5
) (
  input wire logic [N-1:0] vec,
  output logic any,
  output logic [W-1:0] idx
);
  always_comb begin
    any = 1'b0;
    idx = '0;
    // Scan from the bottom of the priority order so position 0 ends up winning
    for (int i = N - 1; i >= 0; i--) begin
      if (vec[i]) begin
        any = 1'b1;
        idx = W'(i);
      end
    end
  end
endmodule

// ---- hw/nest_seq_ctrl.sv ----
// Nested interrupt servicing, idle halt and system register timing control
// Function
// - Mode bit 11 enables nested servicing
// - Nesting lets higher priority preempt lower routines
// - No nesting: no preemption, arrival order service
// - Back-to-back nested take delayed one cycle
// - Per-level mask from pointer, mask register untouched
// - Take sets pointer bit, masks equal/lower
// - Return clears highest pointer bit, remasks
// - Highest pointer bit equals serviced interrupt
// - Second latch write with global enable repeats
// - Latch bit held clear during its routine
// - Jump-clear clears latch, pointer bit, pops status
// - After jump-clear the interrupt may latch again
// - Idle halts until waking interrupt is serviced
// - Idle fetches one more instruction, then suspends
// - Idle keeps DMA, clock and timer running
// - Wake fetches vector after five cycles
// - Saturation enable takes effect two cycles later
// - Mode read sees new value one cycle late
// - Stack pointer write pushes or pops stack
// - Lower bit position means higher priority
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
module nest_seq_ctrl
  import nest_seq_pkg::*;
#(
  parameter int N = nest_seq_pkg::N_IRQ,
  parameter logic [31:0] WAKE_MASK = nest_seq_pkg::WAKE_MASK_DFLT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic [N-1:0] irq_in,
  input wire logic ret_intr,
  input wire logic jci,
  input wire logic idle_exec,
  input wire logic [31:0] fetch_addr,
  output logic svc_take,
  output logic [nest_seq_pkg::VEC_W-1:0] svc_vec,
  output logic sts_pop,
  output logic fetch_one,
  output logic halted,
  output logic wake_fetch,
  output logic sat_active,
  output logic pc_push,
  output logic pc_pop
);
  import nest_seq_pkg::*;

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [31:0] mode;
    logic [N-1:0] mask;
    logic [N-1:0] latch;
    logic [N-1:0] mask_pointer_bits;
    logic [N-1:0] autoclr;
    logic [N-1:0] queued;
    logic [N-1:0][VEC_W-1:0] qmem;
    logic [VEC_W-1:0] qwr;
    logic [VEC_W-1:0] qrd;
    logic [VEC_W:0] qcnt;
    logic hold;
    logic take;
    logic [VEC_W-1:0] vec;
    logic pop;
    logic fone;
    logic wfetch;
    seq_state_t st;
    logic [WAKE_W-1:0] wcnt;
    logic [SAT_DELAY-1:0] satp;
    logic [31:0] mview;
    logic [1:0] rdw;
    logic [PCSP_W-1:0] pcsp;
    logic push;
    logic ppop;
    logic [31:0] rdata;
  } ctl_state_t;

  ctl_state_t s_q;
  ctl_state_t s_d;

  logic nest;
  logic gie;
  logic hp_any;
  logic [VEC_W-1:0] hp_idx;
  logic [N-1:0] tmask;
  logic [N-1:0] enabled;
  logic pend_any;
  logic [VEC_W-1:0] pend_idx;
  logic [N-1:0] newbits;
  logic new_any;
  logic [VEC_W-1:0] new_idx;
  logic [VEC_W-1:0] head;
  logic head_ok;
  logic [VEC_W-1:0] pick;
  logic take_now;
  logic wake_any;
  logic mapped;
  logic wr;
  logic q_pop;
  logic q_push;

  assign nest = s_q.mode[NEST_BIT];
  assign gie = s_q.mode[GIE_BIT];

  // ****************************************
  // Priority pickers
  // ****************************************
  prio_pick #(.N(N), .W(VEC_W)) u_hp (
    .vec(s_q.mask_pointer_bits),
    .any(hp_any),
    .idx(hp_idx)
  );

  prio_pick #(.N(N), .W(VEC_W)) u_pend (
    .vec(enabled),
    .any(pend_any),
    .idx(pend_idx)
  );

  prio_pick #(.N(N), .W(VEC_W)) u_new (
    .vec(newbits),
    .any(new_any),
    .idx(new_idx)
  );

  // ****************************************
  // Temporary mask and selection
  // ****************************************
  always_comb begin
    if (!hp_any) begin
      tmask = '1;
    end else if (nest) begin
      tmask = (N'(1) << hp_idx) - N'(1);
    end else begin
      tmask = '0;
    end
  end

  assign enabled = s_q.latch & s_q.mask & tmask & {N{gie}};
  assign newbits = s_q.latch & ~s_q.queued;
  assign head = s_q.qmem[s_q.qrd];
  assign head_ok = (s_q.qcnt != '0) && enabled[head];
  // Without nesting the oldest arrival goes first; a masked head lets others pass
  assign pick = (!nest && head_ok) ? head : pend_idx;
  assign take_now = pend_any && !s_q.hold && !idle_exec &&
    ((s_q.st == ST_RUN) || (s_q.st == ST_WAKE && s_q.wcnt == WAKE_LAST));
  assign wake_any = |(enabled & WAKE_MASK[N-1:0]);

  // ****************************************
  // APB decode
  // ****************************************
  assign mapped = paddr inside {OFF_MODE, OFF_MASK, OFF_LATCH, OFF_LATCH2,
    OFF_MASKPTR, OFF_PCSP, OFF_FETCH};
  // A mode read right after a mode write waits until the view has caught up
  assign pready = !(psel && !pwrite && paddr == OFF_MODE && s_q.rdw != 2'h0);
  assign pslverr = psel && penable && !mapped;
  assign wr = psel && penable && pwrite && pready;
  assign prdata = s_q.rdata;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.take = 1'b0;
    s_d.pop = 1'b0;
    s_d.fone = 1'b0;
    s_d.wfetch = 1'b0;
    s_d.push = 1'b0;
    s_d.ppop = 1'b0;
    q_pop = 1'b0;
    q_push = 1'b0;

    // Register writes
    if (s_q.rdw != 2'h0) begin
      s_d.rdw = s_q.rdw - 2'h1;
    end
    if (wr) begin
      unique case (paddr)
        OFF_MODE: begin
          s_d.mode = pwdata;
          s_d.rdw = RD_WAIT;
        end
        OFF_MASK: s_d.mask = pwdata[N-1:0];
        OFF_LATCH: s_d.latch = pwdata[N-1:0];
        OFF_LATCH2: begin
          s_d.latch = s_q.latch | pwdata[N-1:0];
          // With interrupts on, the written bit escapes the auto-clear and repeats
          if (gie) begin
            s_d.autoclr = s_q.autoclr & ~pwdata[N-1:0];
          end
        end
        OFF_PCSP: begin
          s_d.pcsp = pwdata[PCSP_W-1:0];
          s_d.push = pwdata[PCSP_W-1:0] > s_q.pcsp;
          s_d.ppop = pwdata[PCSP_W-1:0] < s_q.pcsp;
        end
        default: begin
        end
      endcase
    end

    // Read data is captured while the transfer is open
    if (psel && !pwrite) begin
      unique case (paddr)
        OFF_MODE: s_d.rdata = s_q.mview;
        OFF_MASK: s_d.rdata = 32'(s_q.mask);
        OFF_LATCH: s_d.rdata = 32'(s_q.latch);
        OFF_LATCH2: s_d.rdata = 32'(s_q.mask_pointer_bits);
        OFF_MASKPTR: s_d.rdata = 32'(s_q.mask_pointer_bits);
        OFF_PCSP: s_d.rdata = 32'(s_q.pcsp);
        OFF_FETCH: s_d.rdata = fetch_addr;
        default: s_d.rdata = 32'h0000_0000;
      endcase
    end

    // Return and jump-clear end the current level
    if ((ret_intr || jci) && hp_any) begin
      s_d.mask_pointer_bits[hp_idx] = 1'b0;
      s_d.autoclr[hp_idx] = 1'b0;
      s_d.pop = 1'b1;
      if (jci) begin
        s_d.latch[hp_idx] = 1'b0;
      end
    end

    // New events win over a software clear in the same cycle
    s_d.latch = s_d.latch | irq_in;

    if (take_now) begin
      s_d.take = 1'b1;
      s_d.vec = pick;
      s_d.mask_pointer_bits[pick] = 1'b1;
      s_d.autoclr[pick] = 1'b1;
    end
    s_d.hold = take_now && nest;

    // The routine's own latch bit cannot set again while it runs
    s_d.latch = s_d.latch & ~s_d.autoclr;

    // Arrival order queue
    if (s_q.qcnt != '0 && (!s_q.latch[head] || (take_now && pick == head))) begin
      q_pop = 1'b1;
    end
    if (new_any && (s_q.qcnt < (VEC_W + 1)'(N) || q_pop)) begin
      q_push = 1'b1;
      s_d.qmem[s_q.qwr] = new_idx;
    end
    if (q_pop) begin
      s_d.qrd = s_q.qrd + 1'b1;
    end
    if (q_push) begin
      s_d.qwr = s_q.qwr + 1'b1;
      s_d.queued[new_idx] = 1'b1;
    end
    s_d.queued = s_d.queued & s_d.latch;
    s_d.qcnt = s_q.qcnt + {{VEC_W{1'b0}}, q_push} - {{VEC_W{1'b0}}, q_pop};

    // Idle and wake sequencing
    unique case (s_q.st)
      ST_RUN: begin
        if (idle_exec) begin
          s_d.fone = 1'b1;
          s_d.st = ST_HALT;
        end
      end
      ST_HALT: begin
        if (wake_any) begin
          s_d.st = ST_WAKE;
          s_d.wcnt = '0;
        end
      end
      ST_WAKE: begin
        if (s_q.wcnt == WAKE_LAST) begin
          s_d.st = ST_RUN;
          s_d.wfetch = 1'b1;
        end else begin
          s_d.wcnt = s_q.wcnt + 1'b1;
        end
      end
      default: s_d.st = ST_RUN;
    endcase

    // Delayed views of the mode register
    s_d.mview = s_q.mode;
    s_d.satp = {s_q.satp[SAT_DELAY-2:0], s_q.mode[SAT_BIT]};
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign svc_take = s_q.take;
  assign svc_vec = s_q.vec;
  assign sts_pop = s_q.pop;
  assign fetch_one = s_q.fone;
  // Only the fetch path stalls; latching, bus access and DMA keep running
  assign halted = s_q.st != ST_RUN;
  assign wake_fetch = s_q.wfetch;
  assign sat_active = s_q.satp[SAT_DELAY-1];
  assign pc_push = s_q.push;
  assign pc_pop = s_q.ppop;

  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  chk_nested_preempt_higher: assert property (
    s_q.take && $past(hp_any) && !$past(ret_intr || jci) |-> s_q.vec < $past(hp_idx))
    else $error("preempting interrupt not of higher priority");

  chk_no_nest_preempt: assert property (
    !nest && hp_any && !ret_intr && !jci |=> !s_q.take)
    else $error("preemption while nesting disabled");

  chk_nest_take_gap: assert property (
    s_q.take && $past(s_q.mode[NEST_BIT]) |=> !s_q.take)
    else $error("nested take not delayed one cycle");

  chk_mask_reg_kept: assert property (
    !(wr && paddr == OFF_MASK) |=> $stable(s_q.mask))
    else $error("mask register changed without a write");

  chk_take_sets_ptr: assert property (
    s_q.take |-> s_q.mask_pointer_bits[s_q.vec])
    else $error("taken interrupt missing from pointer");

  chk_return_clears_ptr: assert property (
    (ret_intr || jci) && hp_any |=> !s_q.mask_pointer_bits[$past(hp_idx)])
    else $error("return did not clear highest pointer bit");

  chk_ptr_top_served: assert property (
    s_q.take |-> hp_any && hp_idx == s_q.vec)
    else $error("highest pointer bit differs from served vector");

  chk_latch_held_clear: assert property (
    s_q.take |-> !s_q.latch[s_q.vec])
    else $error("served latch bit not cleared");

  chk_idle_one_fetch: assert property (
    s_q.st == ST_RUN && idle_exec |=> s_q.fone ##1 (!s_q.fone && halted))
    else $error("idle did not fetch exactly one and halt");

  chk_wake_latency: assert property (
    $rose(s_q.st == ST_WAKE) |-> !s_q.wfetch [*5] ##1 s_q.wfetch)
    else $error("wake fetch not after five cycles");

  chk_sat_two_cycles: assert property (
    $rose(s_q.mode[SAT_BIT]) |-> !sat_active ##2 sat_active)
    else $error("saturation not active two cycles after write");

  chk_pcsp_push: assert property (
    wr && paddr == OFF_PCSP && pwdata[PCSP_W-1:0] > s_q.pcsp |=> pc_push && !pc_pop)
    else $error("stack pointer raise did not push");
endmodule

// ---- testbench/core.sv ----
// Behavioural model of the interrupt sources and the core fetch pipeline
`timescale 1ns/1ps
module core (
  input wire logic pclk,
  input wire logic svc_take,
  input wire logic [nest_seq_pkg::VEC_W-1:0] svc_vec,
  input wire logic sts_pop,
  input wire logic wake_fetch,
  input wire logic halted,
  output logic [31:0] irq_in,
  output logic ret_intr,
  output logic jci,
  output logic idle_exec,
  output logic [31:0] fetch_addr
);
  import nest_seq_pkg::*;
  int cyc = 0;
  int icyc = 0;
  int wcyc = 0;
  int pops = 0;
  int tq[$];
  logic [VEC_W-1:0] seen[$];
  initial begin
    irq_in <= 32'h0000_0000;
    {ret_intr, jci, idle_exec} <= 3'h0;
    fetch_addr <= 32'h0000_0000;
  end
  // ****************************************
  // Pipeline view of the block's answers
  // ****************************************
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    // Fetch stands while the core is suspended
    if (halted !== 1'b1) begin
      fetch_addr <= fetch_addr + 32'h0000_0004;
    end
    if (svc_take === 1'b1) begin
      seen.push_back(svc_vec);
      tq.push_back(cyc);
    end
    if (wake_fetch === 1'b1) begin
      wcyc = cyc;
    end
    if (sts_pop === 1'b1) begin
      pops++;
    end
  end
  task automatic clr();
    seen.delete();
    tq.delete();
    pops = 0;
  endtask
  // One-cycle event pulses on a set of sources
  task automatic irq(input logic [31:0] m);
    @(posedge pclk);
    irq_in <= m;
    icyc = cyc;
    @(posedge pclk);
    irq_in <= 32'h0000_0000;
  endtask
  // Two sets of sources on back-to-back cycles
  task automatic irq2(input logic [31:0] a, input logic [31:0] b);
    @(posedge pclk);
    irq_in <= a;
    icyc = cyc;
    @(posedge pclk);
    irq_in <= b;
    @(posedge pclk);
    irq_in <= 32'h0000_0000;
  endtask
  // Jump-clear routines end with a loop-reentry return the block never sees
  task automatic ev(input int k);
    @(posedge pclk);
    ret_intr <= (k == 0);
    jci <= (k == 1);
    idle_exec <= (k == 2);
    @(posedge pclk);
    {ret_intr, jci, idle_exec} <= 3'h0;
  endtask
endmodule

// ---- testbench/tb.sv ----
// Self-checking testbench of the nested interrupt sequencer control block
`timescale 1ns/1ps
`define CHK(a, e) begin \
  cmp_count++; \
  if ((a) !== (e)) begin \
    fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (a), (e)); \
  end \
end
module tb;
  import nest_seq_pkg::*;
  logic pclk = 1'b0;
  logic presetn;
  logic psel;
  logic penable;
  logic pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] rd;
  logic err;
  logic pready, pslverr, ret_intr, jci, idle_exec, svc_take, sts_pop, fetch_one;
  logic halted, wake_fetch, sat_active, pc_push, pc_pop;
  logic [31:0] prdata, irq_in, fetch_addr;
  logic [VEC_W-1:0] svc_vec;
  int fail_count = 0;
  int cmp_count = 0;
  int i0;
  always #12.5 pclk = ~pclk;
  nest_seq_ctrl nest_seq_ctrl_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .prdata(prdata),
    .pslverr(pslverr),
    .irq_in(irq_in),
    .ret_intr(ret_intr),
    .jci(jci),
    .idle_exec(idle_exec),
    .fetch_addr(fetch_addr),
    .svc_take(svc_take),
    .svc_vec(svc_vec),
    .sts_pop(sts_pop),
    .fetch_one(fetch_one),
    .halted(halted),
    .wake_fetch(wake_fetch),
    .sat_active(sat_active),
    .pc_push(pc_push),
    .pc_pop(pc_pop)
  );
  core core_i (
    .pclk(pclk),
    .svc_take(svc_take),
    .svc_vec(svc_vec),
    .sts_pop(sts_pop),
    .wake_fetch(wake_fetch),
    .halted(halted),
    .irq_in(irq_in),
    .ret_intr(ret_intr),
    .jci(jci),
    .idle_exec(idle_exec),
    .fetch_addr(fetch_addr)
  );
  // ****************************************
  // APB master
  // ****************************************
  // Pready, read data and error are taken at the edge that ends the access phase
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // No wait count is assumed; only the watchdog ends a stuck transfer
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    `CHK(rd, e)
  endtask
  // ****************************************
  // Scenarios
  // ****************************************
  task automatic t_regs();
    rdchk(OFF_MODE, MODE_RST);
    rdchk(OFF_MASK, MASK_RST);
    apb(1'b0, 8'h40, 32'h0000_0000);
    `CHK(err, 1'b1)
    apb(1'b1, OFF_MASKPTR, 32'hffff_ffff);
    rdchk(OFF_MASKPTR, 32'h0000_0000);
    apb(1'b1, OFF_MODE, 32'h0000_2000);
    @(negedge pclk);
    `CHK(sat_active, 1'b0)
    rdchk(OFF_MODE, 32'h0000_2000);
    `CHK(sat_active, 1'b1)
    apb(1'b1, OFF_PCSP, 32'h0000_0003);
    @(negedge pclk);
    `CHK(pc_push, 1'b1)
    apb(1'b1, OFF_PCSP, 32'h0000_0001);
    @(negedge pclk);
    `CHK(pc_pop, 1'b1)
    rdchk(OFF_PCSP, 32'h0000_0001);
    $display("register test done");
  endtask
  task automatic t_nest();
    apb(1'b1, OFF_MASK, 32'hffff_ffff);
    apb(1'b1, OFF_MODE, 32'h0000_1800);
    core_i.clr();
    // The higher source arrives the cycle after the lower one
    core_i.irq2(32'h0000_00a0, 32'h0000_0004);
    i0 = core_i.icyc;
    repeat (8) @(posedge pclk);
    `CHK(core_i.seen[0], 5'h05)
    `CHK(core_i.tq[0] - i0, 3)
    `CHK(core_i.seen[1], 5'h02)
    `CHK(core_i.tq[1] - core_i.tq[0], 2)
    rdchk(OFF_MASKPTR, 32'h0000_0024);
    rdchk(OFF_MASK, 32'hffff_ffff);
    core_i.ev(0);
    rdchk(OFF_MASKPTR, 32'h0000_0020);
    `CHK(core_i.seen.size(), 2)
    core_i.ev(0);
    repeat (4) @(posedge pclk);
    `CHK(core_i.seen[2], 5'h07)
    core_i.ev(0);
    repeat (3) @(posedge pclk);
    `CHK(core_i.pops, 3)
    $display("nesting test done");
  endtask
  task automatic t_order();
    apb(1'b1, OFF_MODE, 32'h0000_1000);
    core_i.clr();
    core_i.irq(32'h0000_0020);
    core_i.irq(32'h0000_0200);
    core_i.irq(32'h0000_0008);
    repeat (4) @(posedge pclk);
    `CHK(core_i.seen.size(), 1)
    core_i.ev(0);
    repeat (4) @(posedge pclk);
    `CHK(core_i.seen[1], 5'h09)
    core_i.ev(0);
    repeat (4) @(posedge pclk);
    `CHK(core_i.seen[2], 5'h03)
    core_i.ev(0);
    $display("arrival order test done");
  endtask
  task automatic t_jci();
    apb(1'b1, OFF_MODE, 32'h0000_1800);
    core_i.clr();
    core_i.irq(32'h0000_0040);
    repeat (3) @(posedge pclk);
    core_i.irq(32'h0000_0040);
    rdchk(OFF_LATCH, 32'h0000_0000);
    `CHK(core_i.seen.size(), 1)
    core_i.ev(1);
    rdchk(OFF_MASKPTR, 32'h0000_0000);
    `CHK(core_i.pops, 1)
    core_i.irq(32'h0000_0040);
    repeat (4) @(posedge pclk);
    `CHK(core_i.seen.size(), 2)
    apb(1'b1, OFF_LATCH2, 32'h0000_0040);
    core_i.ev(0);
    repeat (5) @(posedge pclk);
    `CHK(core_i.seen.size(), 3)
    core_i.ev(0);
    $display("jump-clear test done");
  endtask
  task automatic t_idle();
    repeat (3) @(posedge pclk);
    core_i.clr();
    core_i.ev(2);
    @(negedge pclk);
    `CHK(fetch_one, 1'b1)
    repeat (6) @(posedge pclk);
    `CHK(halted, 1'b1)
    rdchk(OFF_FETCH, core_i.fetch_addr);
    core_i.irq(32'h0000_0010);
    repeat (10) @(posedge pclk);
    `CHK(core_i.tq[0] - core_i.icyc, 8)
    `CHK(core_i.wcyc, core_i.tq[0])
    `CHK(halted, 1'b0)
    core_i.ev(0);
    $display("idle test done");
  endtask
  // ****************************************
  // Sequence, watchdog and verdict
  // ****************************************
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    presetn <= 1'b0;
    psel <= 1'b0;
    penable <= 1'b0;
    pwrite <= 1'b0;
    paddr <= 8'h00;
    pwdata <= 32'h0000_0000;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs();
    t_nest();
    t_order();
    t_jci();
    t_idle();
    report_and_stop();
  end
  // The tests need under two hundred cycles; this bound of 3000 cycles is fifteen times that
  initial begin
    #75000;
    fail_count++;
    report_and_stop();
  end
endmodule
